// ### core/ucl_consts.svh
// Register offsets, field positions, reset values and trigger levels of the serial control block.
`ifndef UCL_CONSTS_SVH
`define UCL_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the bus
// ----------------------------------------------------------------------------
`define UCL_OFS_FIFO_SETUP   8'h00
`define UCL_OFS_CHAR_FORMAT  8'h04
`define UCL_OFS_LINE_OUT     8'h08
`define UCL_OFS_ENHANCED     8'h0c
`define UCL_OFS_LINE_IN      8'h10
`define UCL_OFS_STATUS       8'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define UCL_FS_ENABLE        0
`define UCL_FS_RX_FLUSH      1
`define UCL_FS_TX_FLUSH      2
`define UCL_FS_DMA           3
`define UCL_FS_TXTRIG        4
`define UCL_FS_RXTRIG        6
`define UCL_CF_STOP          2
`define UCL_CF_PAR_EN        3
`define UCL_CF_PAR_TYPE      4
`define UCL_CF_PAR_FORCE     5
`define UCL_CF_BREAK         6
`define UCL_CF_DIVISOR       7
`define UCL_LO_TERM_READY    0
`define UCL_LO_SEND_REQ      1
`define UCL_LO_AUX_ONE       2
`define UCL_LO_IRQ_EN        3
`define UCL_LO_LOOPBACK      4
`define UCL_LO_RESUME_ANY    5
`define UCL_EF_ENHANCED      4
`define UCL_EF_AUTO_RTS      6

// ----------------------------------------------------------------------------
// Reset values and trigger levels
// ----------------------------------------------------------------------------
`define UCL_RST_BYTE         8'h00
`define UCL_MIN_DATA_BITS    4'h5
`define UCL_TX_TRIG_0        7'h08
`define UCL_TX_TRIG_1        7'h10
`define UCL_TX_TRIG_2        7'h20
`define UCL_TX_TRIG_3        7'h38
`define UCL_RX_TRIG_0        7'h08
`define UCL_RX_TRIG_1        7'h10
`define UCL_RX_TRIG_2        7'h38
`define UCL_RX_TRIG_3        7'h3c

`endif

// ### core/ucl_pkg.sv
// Types shared by the serial control block.
package ucl_pkg;
    // Parity behaviour handed to the shifters.
    typedef enum logic [2:0] {
        UCL_PAR_NONE  = 3'h0,
        UCL_PAR_ODD   = 3'h1,
        UCL_PAR_EVEN  = 3'h2,
        UCL_PAR_MARK  = 3'h3,
        UCL_PAR_SPACE = 3'h4
    } ucl_parity_t;
    // Stop length handed to the shifters.
    typedef enum logic [1:0] {
        UCL_STOP_ONE      = 2'h0,
        UCL_STOP_ONE_HALF = 2'h1,
        UCL_STOP_TWO      = 2'h2
    } ucl_stop_t;
    // Bus slave states, one-hot.
    typedef enum logic [1:0] {
        UCL_BUS_IDLE   = 2'h1,
        UCL_BUS_RDWAIT = 2'h2
    } ucl_bus_st_t;
endpackage

// ### core/ucl_trig_if.sv
// Carrier between the control block and its trigger lookups.
`timescale 1ns/10ps
interface ucl_trig_if #(parameter int LVL_W = 7);
    logic [1:0]       code;     // Trigger selection code.
    logic [LVL_W-1:0] level;    // Present FIFO fill level.
    logic [LVL_W-1:0] thr;      // Decoded threshold.
    logic             reached;  // Level at or above threshold.
    modport calc (input code, input level, output thr, output reached);
    modport user (output code, output level, input thr, input reached);
endinterface

// ### core/ucl_trig.sv
// Trigger table lookup and level comparison for one FIFO direction.
`timescale 1ns/10ps
`include "ucl_consts.svh"
module ucl_trig #(
    parameter bit IS_TX = 1'b1
) (
    // Trigger carrier.
    ucl_trig_if.calc t
);
    // Decode the code through the table of this direction and compare.
    always_comb begin
        if (IS_TX) begin
            case (t.code)
                2'h0:    t.thr = `UCL_TX_TRIG_0;
                2'h1:    t.thr = `UCL_TX_TRIG_1;
                2'h2:    t.thr = `UCL_TX_TRIG_2;
                default: t.thr = `UCL_TX_TRIG_3;
            endcase
        end else begin
            case (t.code)
                2'h0:    t.thr = `UCL_RX_TRIG_0;
                2'h1:    t.thr = `UCL_RX_TRIG_1;
                2'h2:    t.thr = `UCL_RX_TRIG_2;
                default: t.thr = `UCL_RX_TRIG_3;
            endcase
        end
        t.reached = (t.level >= t.thr);
    end
endmodule // ucl_trig

// ### core/ucl_ctrl.sv
// Control registers and line/modem output logic of one serial channel.
// How it works
// - Receive flush clears receive FIFO, then self-clears.
// - Transmit flush clears transmit FIFO, then self-clears.
// - DMA bit selects ready-pin signalling style.
// - Transmit trigger code selects 8/16/32/56.
// - Transmit interrupt below threshold, or on empty.
// - Transmit trigger writable only with enhanced enable.
// - Latest trigger selection governs both directions; here transmit and receive keep separate code fields.
// - Receive trigger 8/16/56/60; interrupt at threshold.
// - Length field gives five to eight bits.
// - Stop bit gives one, one-half or two.
// - Parity enable adds and checks parity bit.
// - Parity type bit picks odd or even.
// - Force bit fixes parity to mark/space.
// - Break bit holds transmit output at space.
// - Divisor bit redirects shared addresses to divisor.
// - Terminal-ready pin is inverse of bit.
// - Send-request pin inverse; auto flow may override.
// - Auxiliary one feeds ring input in loopback.
// - Interrupt pin driven when select or enable.
// - Auxiliary two is inverse enable in loopback.
// - Loopback bit selects internal local loopback.
// - Any character resumes halted transmitter; flow chars dropped.
// - FIFO bits ignored unless enable written too.
// - Loopback clear-to-send status follows send-request bit.
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "ucl_consts.svh"
module ucl_ctrl (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Datapath state, same clock.
    input  wire logic [6:0]  tx_level,
    input  wire logic [6:0]  rx_level,
    input  wire logic        tx_serial,
    input  wire logic        rx_char_valid,
    input  wire logic        rx_char_flow_match,
    input  wire logic        sw_flow_active,
    input  wire logic        sw_flow_halted,
    input  wire logic        auto_rts_n,
    input  wire logic        irq_request,
    // Asynchronous pins.
    input  wire logic        irq_drive_select_pin,
    input  wire logic        cts_n_pin,
    input  wire logic        dsr_n_pin,
    input  wire logic        ri_n_pin,
    input  wire logic        cd_n_pin,
    // Datapath control.
    output logic             fifo_enable,
    output logic             rx_fifo_flush,
    output logic             tx_fifo_flush,
    output logic             dma_mode,
    output logic      [3:0]  data_bits,
    output logic      [1:0]  stop_len,
    output logic      [2:0]  parity_mode,
    output logic             divisor_select,
    output logic             loopback,
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             tx_resume,
    output logic             rx_store,
    output logic             aux_output_one,
    output logic             aux_output_two,
    // Output pins.
    output logic             tx_pin,
    output logic             dtr_n_pin,
    output logic             rts_n_pin,
    output logic             irq_pin,
    output logic             irq_pin_oe,
    output logic             transmit_space_pin_n,
    output logic             receive_avail_pin_n
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    ucl_pkg::ucl_bus_st_t bus_st_r;       // Bus slave state.
    logic                 wr_pend_r;      // Write data phase follows.
    logic [7:0]           wr_addr_r;      // Latched write offset.
    logic [7:0]           rd_addr_r;      // Latched read offset.
    logic [7:0]           fifo_setup_r;   // Enable, DMA and trigger fields.
    logic [7:0]           char_format_r;  // Character format.
    logic [7:0]           line_out_r;     // Modem and interrupt output control.
    logic [7:0]           enhanced_r;     // Enhanced function bits.
    logic [4:0]           pin_meta_r;     // First synchroniser stage.
    logic [4:0]           pin_sync_r;     // Second synchroniser stage.
    logic                 filled_r;       // Last reload went past threshold.
    logic [7:0]           line_in_nxt;    // Modem input status view.
    logic                 accept;         // Address phase taken this cycle.
    logic                 fs_write;       // Data phase write to fifo setup.
    logic [7:0]           fs_data;        // Byte written to fifo setup.

    ucl_trig_if #(.LVL_W(7)) tx_t ();
    ucl_trig_if #(.LVL_W(7)) rx_t ();

    assign accept   = hsel && hready && htrans[1] && (bus_st_r == ucl_pkg::UCL_BUS_IDLE);
    assign fs_write = wr_pend_r && (wr_addr_r == `UCL_OFS_FIFO_SETUP);
    assign fs_data  = hwdata[7:0];

    // ------------------------------------------------------------------------
    // Trigger lookups
    // ------------------------------------------------------------------------
    // Both lookups read fields of the one stored selection byte.
    assign tx_t.code  = fifo_setup_r[`UCL_FS_TXTRIG+1:`UCL_FS_TXTRIG];
    assign tx_t.level = tx_level;
    assign rx_t.code  = fifo_setup_r[`UCL_FS_RXTRIG+1:`UCL_FS_RXTRIG];
    assign rx_t.level = rx_level;

    ucl_trig #(.IS_TX(1'b1)) u_tx_trig (
        .t (tx_t)
    );
    ucl_trig #(.IS_TX(1'b0)) u_rx_trig (
        .t (rx_t)
    );

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------
    // Writes complete with no wait; reads take one wait state so that a read
    // right behind a write already sees the written value.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_st_r  <= ucl_pkg::UCL_BUS_IDLE;
            hreadyout <= 1'b1;
            rd_addr_r <= 8'h00;
        end else begin
            case (bus_st_r)
                ucl_pkg::UCL_BUS_IDLE: begin
                    // A taken read stalls its data phase for one cycle.
                    if (accept && !hwrite) begin
                        bus_st_r  <= ucl_pkg::UCL_BUS_RDWAIT;
                        hreadyout <= 1'b0;
                        rd_addr_r <= {haddr[7:2], 2'b00};
                    end
                end
                ucl_pkg::UCL_BUS_RDWAIT: begin
                    // Read data is loaded now and stands with hreadyout.
                    bus_st_r  <= ucl_pkg::UCL_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    bus_st_r  <= ucl_pkg::UCL_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // Latch a write address phase; the data arrives one cycle later.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= accept && hwrite;
            if (accept && hwrite) begin
                wr_addr_r <= {haddr[7:2], 2'b00};
            end
        end
    end

    // The response is always OKAY.
    always_ff @(posedge clk) begin
        hresp <= 1'b0;
    end

    // Read data mux; unmapped and write-only offsets read as zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (bus_st_r == ucl_pkg::UCL_BUS_RDWAIT) begin
            case (rd_addr_r)
                `UCL_OFS_CHAR_FORMAT: hrdata <= {24'h000000, char_format_r};
                `UCL_OFS_LINE_OUT:    hrdata <= {24'h000000, line_out_r};
                `UCL_OFS_ENHANCED:    hrdata <= {24'h000000, enhanced_r};
                `UCL_OFS_LINE_IN:     hrdata <= {24'h000000, line_in_nxt};
                `UCL_OFS_STATUS:      hrdata <= {29'h00000000, filled_r, rx_irq, tx_irq};
                default:              hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Fifo setup: a write without the enable bit only turns the FIFOs off,
    // every other field keeps its value.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_setup_r <= `UCL_RST_BYTE;
        end else if (fs_write) begin
            fifo_setup_r[`UCL_FS_ENABLE] <= fs_data[`UCL_FS_ENABLE];
            if (fs_data[`UCL_FS_ENABLE]) begin
                fifo_setup_r[`UCL_FS_DMA] <= fs_data[`UCL_FS_DMA];
                // One selection byte feeds both lookups; each write with the enable bit sets the receive field,
                // and sets the transmit field only while the enhanced bit is set.
                fifo_setup_r[`UCL_FS_RXTRIG+1:`UCL_FS_RXTRIG] <=
                    fs_data[`UCL_FS_RXTRIG+1:`UCL_FS_RXTRIG];
                if (enhanced_r[`UCL_EF_ENHANCED]) begin
                    fifo_setup_r[`UCL_FS_TXTRIG+1:`UCL_FS_TXTRIG] <=
                        fs_data[`UCL_FS_TXTRIG+1:`UCL_FS_TXTRIG];
                end
            end
        end
    end

    // Character format, line output control and enhanced function bits.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            char_format_r <= `UCL_RST_BYTE;
            line_out_r    <= `UCL_RST_BYTE;
            enhanced_r    <= `UCL_RST_BYTE;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                `UCL_OFS_CHAR_FORMAT: char_format_r <= hwdata[7:0];
                `UCL_OFS_LINE_OUT:    line_out_r    <= {2'b00, hwdata[5:0]};
                `UCL_OFS_ENHANCED:    enhanced_r    <= hwdata[7:0];
                default:              ;
            endcase
        end
    end

    // Flush strobes last one cycle, so the flush bits read back as zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_fifo_flush <= 1'b0;
            tx_fifo_flush <= 1'b0;
        end else begin
            rx_fifo_flush <= fs_write && fs_data[`UCL_FS_ENABLE] && fs_data[`UCL_FS_RX_FLUSH];
            tx_fifo_flush <= fs_write && fs_data[`UCL_FS_ENABLE] && fs_data[`UCL_FS_TX_FLUSH];
        end
    end

    // ------------------------------------------------------------------------
    // Format decode
    // ------------------------------------------------------------------------
    // Character format fields become ready-made controls for the shifters.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_bits      <= `UCL_MIN_DATA_BITS;
            stop_len       <= ucl_pkg::UCL_STOP_ONE;
            parity_mode    <= ucl_pkg::UCL_PAR_NONE;
            divisor_select <= 1'b0;
        end else begin
            data_bits <= `UCL_MIN_DATA_BITS + {2'b00, char_format_r[1:0]};
            if (!char_format_r[`UCL_CF_STOP]) begin
                stop_len <= ucl_pkg::UCL_STOP_ONE;
            end else if (char_format_r[1:0] == 2'b00) begin
                stop_len <= ucl_pkg::UCL_STOP_ONE_HALF;
            end else begin
                stop_len <= ucl_pkg::UCL_STOP_TWO;
            end
            if (!char_format_r[`UCL_CF_PAR_EN]) begin
                parity_mode <= ucl_pkg::UCL_PAR_NONE;
            end else if (char_format_r[`UCL_CF_PAR_FORCE]) begin
                parity_mode <= char_format_r[`UCL_CF_PAR_TYPE] ? ucl_pkg::UCL_PAR_SPACE
                                                               : ucl_pkg::UCL_PAR_MARK;
            end else begin
                parity_mode <= char_format_r[`UCL_CF_PAR_TYPE] ? ucl_pkg::UCL_PAR_EVEN
                                                               : ucl_pkg::UCL_PAR_ODD;
            end
            divisor_select <= char_format_r[`UCL_CF_DIVISOR];
        end
    end

    // ------------------------------------------------------------------------
    // FIFO triggers and ready pins
    // ------------------------------------------------------------------------
    // Remember whether the transmit FIFO was loaded past its threshold, so
    // a short reload asks for data only once it has drained completely.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            filled_r <= 1'b0;
        end else if (tx_level > tx_t.thr) begin
            // A fill seen in the flush cycle wins; the level reads zero next.
            filled_r <= 1'b1;
        end else if (tx_fifo_flush || tx_level == 7'h00) begin
            filled_r <= 1'b0;
        end
    end

    // Transmit and receive interrupt requests and the two ready pins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_enable          <= 1'b0;
            dma_mode             <= 1'b0;
            tx_irq               <= 1'b0;
            rx_irq               <= 1'b0;
            transmit_space_pin_n <= 1'b1;
            receive_avail_pin_n  <= 1'b1;
        end else begin
            fifo_enable <= fifo_setup_r[`UCL_FS_ENABLE];
            dma_mode    <= fifo_setup_r[`UCL_FS_DMA];
            tx_irq <= fifo_setup_r[`UCL_FS_ENABLE] &&
                      (filled_r ? !tx_t.reached : (tx_level == 7'h00));
            rx_irq <= fifo_setup_r[`UCL_FS_ENABLE] && rx_t.reached;
            if (fifo_setup_r[`UCL_FS_DMA]) begin
                // DMA style: request in bursts around the thresholds.
                transmit_space_pin_n <= tx_t.reached;
                receive_avail_pin_n  <= !rx_t.reached;
            end else begin
                // Normal style: single-character readiness.
                transmit_space_pin_n <= (tx_level != 7'h00);
                receive_avail_pin_n  <= (rx_level == 7'h00);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Modem inputs
    // ------------------------------------------------------------------------
    // Two-stage synchroniser; only the second stage is read by logic.
    // Modem inputs rest inactive high, the drive select rests low, so the
    // interrupt driver is not switched on for a moment after reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_meta_r <= 5'h1e;
            pin_sync_r <= 5'h1e;
        end else begin
            pin_meta_r <= {cd_n_pin, ri_n_pin, dsr_n_pin, cts_n_pin, irq_drive_select_pin};
            pin_sync_r <= pin_meta_r;
        end
    end

    // Status bits are active-high views of the inputs, or of the output
    // bits when the channel is looped back on itself.
    always_comb begin
        line_in_nxt = 8'h00;
        if (line_out_r[`UCL_LO_LOOPBACK]) begin
            line_in_nxt[4] = line_out_r[`UCL_LO_SEND_REQ];
            line_in_nxt[5] = line_out_r[`UCL_LO_TERM_READY];
            line_in_nxt[6] = line_out_r[`UCL_LO_AUX_ONE];
            line_in_nxt[7] = line_out_r[`UCL_LO_IRQ_EN];
        end else begin
            line_in_nxt[4] = !pin_sync_r[1];
            line_in_nxt[5] = !pin_sync_r[2];
            line_in_nxt[6] = !pin_sync_r[3];
            line_in_nxt[7] = !pin_sync_r[4];
        end
    end

    // ------------------------------------------------------------------------
    // Line and modem outputs
    // ------------------------------------------------------------------------
    // In loopback the external outputs rest inactive, except tx_pin held at space by break, and the internal
    // auxiliary signals carry the control bits instead.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loopback       <= 1'b0;
            tx_pin         <= 1'b1;
            dtr_n_pin      <= 1'b1;
            rts_n_pin      <= 1'b1;
            aux_output_one <= 1'b0;
            aux_output_two <= 1'b1;
        end else begin
            loopback <= line_out_r[`UCL_LO_LOOPBACK];
            if (char_format_r[`UCL_CF_BREAK]) begin
                tx_pin <= 1'b0;
            end else begin
                tx_pin <= line_out_r[`UCL_LO_LOOPBACK] ? 1'b1 : tx_serial;
            end
            if (line_out_r[`UCL_LO_LOOPBACK]) begin
                dtr_n_pin <= 1'b1;
                rts_n_pin <= 1'b1;
            end else begin
                dtr_n_pin <= !line_out_r[`UCL_LO_TERM_READY];
                rts_n_pin <= enhanced_r[`UCL_EF_AUTO_RTS] ? auto_rts_n
                                                          : !line_out_r[`UCL_LO_SEND_REQ];
            end
            aux_output_one <= line_out_r[`UCL_LO_AUX_ONE];
            aux_output_two <= !line_out_r[`UCL_LO_IRQ_EN];
        end
    end

    // Interrupt pin drive: the enable bit or the select pin turns it on.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_pin    <= 1'b0;
            irq_pin_oe <= 1'b0;
        end else begin
            irq_pin    <= irq_request;
            irq_pin_oe <= pin_sync_r[0] || line_out_r[`UCL_LO_IRQ_EN];
        end
    end

    // ------------------------------------------------------------------------
    // Resume on any character
    // ------------------------------------------------------------------------
    // Flow characters are kept out of the FIFO only while software flow
    // control is using them; everything else is stored.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_resume <= 1'b0;
            rx_store  <= 1'b0;
        end else begin
            tx_resume <= rx_char_valid && line_out_r[`UCL_LO_RESUME_ANY] && sw_flow_halted;
            rx_store  <= rx_char_valid && !(rx_char_flow_match && sw_flow_active);
        end
    end

endmodule // ucl_ctrl

// ### verif/ucl_host.sv
// Host bus master model driving single word transfers.
`timescale 1ns/10ps
module ucl_host (
    input  logic        clk,
    input  logic        hreadyout,
    input  logic [31:0] hrdata,
    output logic        hsel = 0,
    output logic        hwrite = 0,
    output logic [1:0]  htrans = 0,
    output logic [31:0] haddr = 0,
    output logic [31:0] hwdata = 0
);
    // Ready and read data are taken at the rising edge, before that edge's updates land.
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel <= 1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
endmodule // ucl_host

// ### verif/ucl_ctrl_properties.sv
// Port properties of the serial control block.
`timescale 1ns/10ps
module ucl_chk (
    input logic clk, rst_n, fifo_enable, rx_fifo_flush, loopback, dtr_n_pin, rts_n_pin,
    input logic aux_output_two, irq_pin_oe, rx_irq, tx_irq,
    input logic [3:0] data_bits,
    input logic [1:0] stop_len,
    input logic [2:0] parity_mode,
    input logic [6:0] tx_level, rx_level
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_flush_once: assert property (rx_fifo_flush |=> !rx_fifo_flush && fifo_enable) else $error("flush");
    a_len_range: assert property (data_bits inside {[5:8]}) else $error("length");
    a_stop_code: assert property (stop_len < 3 && ((stop_len == 1) == (stop_len > 0 && data_bits == 5)))
        else $error("stop");
    a_par_code: assert property (parity_mode < 5) else $error("parity");
    a_oe_enable: assert property (!aux_output_two |-> irq_pin_oe) else $error("irq enable");
    a_loop_quiet: assert property (loopback && $past(loopback) |-> dtr_n_pin && rts_n_pin) else $error("loop");
    a_rx_level: assert property (rx_irq |-> $past(rx_level) >= 8) else $error("rx irq");
    a_tx_level: assert property (tx_irq |-> $past(tx_level) < 56) else $error("tx irq");
    c_flush: cover property (rx_fifo_flush);
    c_rx_irq: cover property (rx_irq);
    c_loop: cover property (loopback);
endmodule // ucl_chk
bind ucl_ctrl ucl_chk chk (.*);

// ### verif/testbench.sv
// Self-checking bench of the serial control block.
`timescale 1ns/10ps
module testbench;
    logic clk = 0, rst_n = 0, tx_serial = 1, irq_drive_select_pin = 0;
    logic [3:0] sr = 0, st = 0;
    logic rx_char_valid = 0, rx_char_flow_match = 0, sw_flow_active = 0, sw_flow_halted = 0, irq_request = 0;
    logic auto_rts_n = 1, cts_n_pin = 1, dsr_n_pin = 1, ri_n_pin = 1, cd_n_pin = 1, hsel, hwrite, hresp;
    logic hreadyout, fifo_enable, dma_mode, rx_fifo_flush, tx_fifo_flush, divisor_select, loopback, tx_irq;
    logic rx_irq, tx_resume, rx_store, aux_output_one, aux_output_two, tx_pin, dtr_n_pin, rts_n_pin, irq_pin;
    logic irq_pin_oe, transmit_space_pin_n, receive_avail_pin_n;
    logic [1:0] htrans, stop_len;
    logic [2:0] hsize = 2, parity_mode;
    logic [3:0] data_bits;
    logic [6:0] tx_level = 0, rx_level = 0;
    logic [31:0] hrdata, haddr, hwdata, q;
    wire hready = hreadyout;
    int mismatches = 0, compares = 0;
    ucl_ctrl dut (.*);
    ucl_host host (.*);
    always #25 clk = ~clk;
    // Flush strobes last one cycle only, so they are counted here.
    always @(posedge clk) begin
        if (rx_fifo_flush) sr <= sr + 4'h1;
        if (tx_fifo_flush) st <= st + 4'h1;
    end
    task chk(input string n, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task w(input logic [7:0] a, d);
        host.xf(1, a, {24'h0, d}, q);
        repeat (2) @(posedge clk);
        #1;
    endtask
    task lv(input logic [6:0] t, r);
        @(posedge clk);
        tx_level <= t; rx_level <= r;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task print_verdict;
        if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task t_fmt;
        for (int i = 0; i < 8; i++) begin
            w(4, {i[2:0], 1'b0, i[1:0]});
            chk("len", data_bits, 5 + i[1:0]);
            chk("par", parity_mode, !i[0] ? 0 : i[2] ? 3 + i[1] : 1 + i[1]);
            host.xf(0, 4, 0, q);
            chk("fmt", q, {i[2:0], 1'b0, i[1:0]});
        end
        w(4, 8'h04); chk("stop", stop_len, 1);
        w(4, 8'hc7); chk("stop", stop_len, 2); chk("brk", tx_pin, 0); chk("div", divisor_select, 1);
        w(4, 0);
    endtask
    task t_mdm;
        w(8, 8'h03); chk("dtr", dtr_n_pin, 0); chk("rts", rts_n_pin, 0); chk("oe", irq_pin_oe, 0);
        @(posedge clk);
        irq_drive_select_pin <= 1;
        repeat (4) @(posedge clk);
        #1 chk("oe", irq_pin_oe, 1);
        @(posedge clk);
        irq_drive_select_pin <= 0;
        w(8, 8'h1e); chk("lpb", loopback, 1); chk("ax1", aux_output_one, 1);
        chk("ax2", aux_output_two, 0); chk("oe", irq_pin_oe, 1); chk("rts", rts_n_pin, 1);
        host.xf(0, 8'h10, 0, q); chk("lst", q, 8'hd0);
        w(8, 0);
    endtask
    task t_fifo;
        w(8'h0c, 8'h10); w(0, 8'h07);
        chk("rfl", sr, 1); chk("tfl", st, 1); chk("en", fifo_enable, 1);
        w(0, 8'h0e); chk("rfl", sr, 1); chk("tfl", st, 1); chk("en", fifo_enable, 0);
        w(0, 8'hc9); chk("dma", dma_mode, 1);
        lv(0, 59); chk("rxi", rx_irq, 0); lv(0, 60); chk("rxi", rx_irq, 1);
        chk("rxr", receive_avail_pin_n, 0);
        lv(0, 10); w(0, 8'h31); chk("rxi", rx_irq, 1);
        lv(57, 0); chk("txi", tx_irq, 0); lv(55, 0); chk("txi", tx_irq, 1);
        w(8'h0c, 0); w(0, 8'h01); chk("txi", tx_irq, 1);
        lv(0, 0); chk("txi", tx_irq, 1); lv(3, 0); chk("txi", tx_irq, 0);
        chk("txr", transmit_space_pin_n, 1);
    endtask
    // One received character; the one-cycle answers are judged while they stand.
    task rxc(input logic m, h, input logic [1:0] e);
        @(posedge clk);
        rx_char_valid <= 1; rx_char_flow_match <= m; sw_flow_halted <= h;
        @(posedge clk);
        rx_char_valid <= 0;
        #1 chk("res", tx_resume, e[1]);
        chk("sto", rx_store, e[0]);
    endtask
    task t_flow;
        @(posedge clk);
        sw_flow_active <= 1; irq_request <= 1;
        rxc(0, 1, 2'h1); w(8, 8'h20); rxc(1, 1, 2'h2); rxc(0, 0, 2'h1);
        chk("irq", irq_pin, 1); chk("rsp", hresp, 0);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        host.xf(0, 8'h20, 0, q);
        chk("gap", q, 0); chk("dtr", dtr_n_pin, 1); chk("len", data_bits, 5);
        t_fmt; t_mdm; t_fifo; t_flow;
        print_verdict;
    end
    initial begin
        #200000;
        mismatches++;
        print_verdict;
    end
endmodule // testbench
